// [dpm_cfg_if.sv]
// interface carrying the serially written configuration between modules
`timescale 1ns/10ps
interface dpm_cfg_if;
   logic wr_map_a;
   logic wr_map_b;
   logic wr_ch_on;
   logic [7:0] wdata;
   logic clear;
   logic [7:0] map_a;
   logic [7:0] map_b;
   logic [7:0] ch_on;
   modport ctrl (output wr_map_a, output wr_map_b, output wr_ch_on, output wdata, output clear,
      input map_a, input map_b, input ch_on);
   modport regs (input wr_map_a, input wr_map_b, input wr_ch_on, input wdata, input clear,
      output map_a, output map_b, output ch_on);
endinterface : dpm_cfg_if

// [dpm_host_model.sv]
// host model driving the direct inputs and the request pin
`timescale 1ns/10ps
module dpm_host_model #(
   parameter int HOLD_CYC = 4
) (
   input wire logic clk,
   input wire logic a_cmd,
   input wire logic b_cmd,
   input wire logic req_cmd,
   output logic direct_input_a,
   output logic direct_input_b,
   output logic low_power_req_b
);
   int hold_q = 0;
   // pins move on the falling edge; a new request level waits out the hold time
   initial begin
      direct_input_a = 1'b0;
      direct_input_b = 1'b0;
      low_power_req_b = 1'b1;
      forever begin
         @(negedge clk);
         direct_input_a = a_cmd;
         direct_input_b = b_cmd;
         if (hold_q > 0) begin
            hold_q--;
         end else if (req_cmd !== low_power_req_b) begin
            low_power_req_b = req_cmd;
            hold_q = HOLD_CYC;
         end
      end
   end
endmodule : dpm_host_model

// [dpm_pkg.sv]
// package of constants and types for the direct pin mode control block
package dpm_pkg;
   localparam int NUM_CH = 8;
   localparam logic [7:0] MAP_A_RESET = 8'h04; // channel 2
   localparam logic [7:0] MAP_B_RESET = 8'h08; // channel 3
   localparam logic [7:0] CH_ON_RESET = 8'h00;
   localparam logic [1:0] MON_RESET = 2'h0;
   typedef enum logic [1:0] {
      DPM_NORMAL = 2'b00,
      DPM_LIMP = 2'b01,
      DPM_SLEEP = 2'b11
   } dpm_mode_type;
endpackage : dpm_pkg

// [dpm_regs.sv]
// mapping and channel-on register bank
`timescale 1ns/10ps
module dpm_regs (
   input wire logic clk,
   input wire logic rst_b,
   dpm_cfg_if.regs cfg
);
   logic [7:0] map_a_q;
   logic [7:0] map_b_q;
   logic [7:0] ch_on_q;

   // clear from low-power request beats any write
   always_ff @(posedge clk) begin
      if (!rst_b || cfg.clear) begin
         map_a_q <= dpm_pkg::MAP_A_RESET;
         map_b_q <= dpm_pkg::MAP_B_RESET;
         ch_on_q <= dpm_pkg::CH_ON_RESET;
      end else begin
         if (cfg.wr_map_a) map_a_q <= cfg.wdata;
         if (cfg.wr_map_b) map_b_q <= cfg.wdata;
         if (cfg.wr_ch_on) ch_on_q <= cfg.wdata;
      end
   end

   assign cfg.map_a = map_a_q;
   assign cfg.map_b = map_b_q;
   assign cfg.ch_on = ch_on_q;

   chk_clear_defaults: assert property (@(posedge clk) disable iff (!rst_b)
      cfg.clear |=> (map_a_q == dpm_pkg::MAP_A_RESET && map_b_q == dpm_pkg::MAP_B_RESET
         && ch_on_q == dpm_pkg::CH_ON_RESET)) else $error("registers not at default after clear");
endmodule : dpm_regs

// [dpm_top.sv]
// top of the direct pin mode control block
`timescale 1ns/10ps
module dpm_top #(
   parameter int NUM_CH = dpm_pkg::NUM_CH
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic direct_input_a,
   input wire logic direct_input_b,
   input wire logic low_power_req_b,
   input wire logic wr_map_a,
   input wire logic wr_map_b,
   input wire logic wr_ch_on,
   input wire logic [7:0] wdata,
   input wire logic serial_cs_b,
   input wire logic serial_out_data,
   output logic [NUM_CH-1:0] channel_on,
   output logic [7:0] input_a_channel_map,
   output logic [7:0] input_b_channel_map,
   output logic [7:0] channel_on_reg,
   output logic [1:0] input_level_monitor,
   output logic sleep_mode,
   output logic limp_mode,
   output logic uv_detect_en,
   output logic serial_access_en,
   output logic serial_out,
   output logic serial_out_oe
);
   dpm_cfg_if cfg ();
   dpm_pkg::dpm_mode_type mode_d;
   dpm_pkg::dpm_mode_type mode_q;
   logic [NUM_CH-1:0] ch_d;
   logic [NUM_CH-1:0] ch_q;
   logic [1:0] mon_q;
   logic so_q;
   logic so_oe_q;

   dpm_regs u_regs (
      .clk(clk),
      .rst_b(rst_b),
      .cfg(cfg)
   );

   // mode from request pin and inputs; the host keeps the pin stable, so no filter
   always_comb begin
      mode_d = dpm_pkg::DPM_NORMAL;
      if (!low_power_req_b) begin
         if (direct_input_a || direct_input_b) mode_d = dpm_pkg::DPM_LIMP;
         else mode_d = dpm_pkg::DPM_SLEEP;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) mode_q <= dpm_pkg::DPM_NORMAL;
      else mode_q <= mode_d;
   end

   // serial writes blocked while request is low; clear held meanwhile
   assign cfg.clear = !low_power_req_b;
   assign cfg.wr_map_a = wr_map_a && low_power_req_b;
   assign cfg.wr_map_b = wr_map_b && low_power_req_b;
   assign cfg.wr_ch_on = wr_ch_on && low_power_req_b;
   assign cfg.wdata = wdata;

   // limp home ignores programmed maps, uses default channels only
   always_comb begin
      ch_d = '0;
      if (mode_d == dpm_pkg::DPM_LIMP) begin
         ch_d = ({8{direct_input_a}} & dpm_pkg::MAP_A_RESET)
            | ({8{direct_input_b}} & dpm_pkg::MAP_B_RESET);
      end else if (mode_d == dpm_pkg::DPM_NORMAL) begin
         ch_d = cfg.ch_on | ({8{direct_input_a}} & cfg.map_a)
            | ({8{direct_input_b}} & cfg.map_b);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) ch_q <= '0;
      else ch_q <= ch_d;
   end

   // monitor runs in every mode including limp home
   always_ff @(posedge clk) begin
      if (!rst_b) mon_q <= dpm_pkg::MON_RESET;
      else mon_q <= {direct_input_b, direct_input_a};
   end

   // serial output tri-stated in sleep even with chip select low
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         so_q <= 1'b0;
         so_oe_q <= 1'b0;
      end else begin
         so_q <= serial_out_data;
         so_oe_q <= !serial_cs_b && (mode_d != dpm_pkg::DPM_SLEEP);
      end
   end

   assign channel_on = ch_q;
   assign input_a_channel_map = cfg.map_a;
   assign input_b_channel_map = cfg.map_b;
   assign channel_on_reg = cfg.ch_on;
   assign input_level_monitor = mon_q;
   assign sleep_mode = (mode_q == dpm_pkg::DPM_SLEEP);
   assign limp_mode = (mode_q == dpm_pkg::DPM_LIMP);
   assign uv_detect_en = (mode_q != dpm_pkg::DPM_SLEEP);
   assign serial_access_en = (mode_q == dpm_pkg::DPM_NORMAL);
   assign serial_out = so_q;
   assign serial_out_oe = so_oe_q;

   chk_limp_default_ch: assert property (@(posedge clk) disable iff (!rst_b)
      (!low_power_req_b && direct_input_a && !direct_input_b) |=> (channel_on == dpm_pkg::MAP_A_RESET))
      else $error("limp home channel wrong");
   chk_sleep_entry: assert property (@(posedge clk) disable iff (!rst_b)
      (!low_power_req_b && !direct_input_a && !direct_input_b) |=> (sleep_mode && !uv_detect_en && channel_on == '0))
      else $error("sleep not entered");
   chk_or_combine: assert property (@(posedge clk) disable iff (!rst_b)
      low_power_req_b |=> (channel_on == ($past(cfg.ch_on) | ({8{$past(direct_input_a)}} & $past(cfg.map_a))
         | ({8{$past(direct_input_b)}} & $past(cfg.map_b))))) else $error("channel OR wrong");
   chk_monitor_track: assert property (@(posedge clk) disable iff (!rst_b)
      1'b1 |=> (input_level_monitor == {$past(direct_input_b), $past(direct_input_a)}))
      else $error("monitor lag");
   chk_so_sleep_hiz: assert property (@(posedge clk) disable iff (!rst_b)
      (!low_power_req_b && !direct_input_a && !direct_input_b && !serial_cs_b) |=> !serial_out_oe)
      else $error("serial output driven in sleep");
   chk_write_blocked: assert property (@(posedge clk) disable iff (!rst_b)
      (!low_power_req_b && wr_map_a) |=> (input_a_channel_map == dpm_pkg::MAP_A_RESET))
      else $error("write taken in low power");
   chk_map_write: assert property (@(posedge clk) disable iff (!rst_b)
      (low_power_req_b && wr_map_b) |=> (input_b_channel_map == $past(wdata))) else $error("map write lost");
   chk_resume_normal: assert property (@(posedge clk) disable iff (!rst_b)
      ($rose(low_power_req_b)) |=> (serial_access_en && !sleep_mode && !limp_mode
         && input_a_channel_map == dpm_pkg::MAP_A_RESET))
      else $error("no resume to normal");

   // request pin patterns; each is one sampled level, the steps are built on them below
   sequence seq_sleep_req;
      !low_power_req_b && !direct_input_a && !direct_input_b;
   endsequence : seq_sleep_req

   sequence seq_limp_req;
      !low_power_req_b && (direct_input_a || direct_input_b);
   endsequence : seq_limp_req

   sequence seq_normal_req;
      low_power_req_b;
   endsequence : seq_normal_req

   // reset puts every register back to its default, no disable so the reset itself is seen
   chk_reset_regs: assert property (@(posedge clk)
      !rst_b |=> (input_a_channel_map == dpm_pkg::MAP_A_RESET && input_b_channel_map == dpm_pkg::MAP_B_RESET
         && channel_on_reg == dpm_pkg::CH_ON_RESET && channel_on == '0))
      else $error("registers not at default after reset");

   // monitor starts from its reset value
   chk_reset_monitor: assert property (@(posedge clk)
      !rst_b |=> (input_level_monitor == dpm_pkg::MON_RESET))
      else $error("monitor not cleared by reset");

   // reset leaves the block in normal mode with the serial output released
   chk_reset_mode: assert property (@(posedge clk)
      !rst_b |=> (!sleep_mode && !limp_mode && uv_detect_en && serial_access_en && !serial_out_oe))
      else $error("mode wrong after reset");

   // input b alone in limp home drives channel 3 only
   chk_limp_b_only: assert property (@(posedge clk) disable iff (!rst_b)
      (!low_power_req_b && !direct_input_a && direct_input_b) |=> (channel_on == dpm_pkg::MAP_B_RESET))
      else $error("limp home channel b wrong");

   // both inputs high in limp home drive both default channels
   chk_limp_both: assert property (@(posedge clk) disable iff (!rst_b)
      (!low_power_req_b && direct_input_a && direct_input_b)
      |=> (channel_on == (dpm_pkg::MAP_A_RESET | dpm_pkg::MAP_B_RESET)))
      else $error("limp home both channels wrong");

   // limp home flag follows the request pattern one cycle later
   chk_limp_flag: assert property (@(posedge clk) disable iff (!rst_b)
      seq_limp_req |=> (limp_mode && !sleep_mode))
      else $error("limp home not entered");

   // programmed channel-on bits must not leak into limp home
   chk_limp_no_chon: assert property (@(posedge clk) disable iff (!rst_b)
      seq_limp_req |=> ((channel_on & ~(dpm_pkg::MAP_A_RESET | dpm_pkg::MAP_B_RESET)) == '0))
      else $error("limp home drives a mapped channel");

   // detectors only switch off when both inputs are low too
   chk_limp_uv_on: assert property (@(posedge clk) disable iff (!rst_b)
      seq_limp_req |=> uv_detect_en)
      else $error("undervoltage detect off in limp home");

   // monitor keeps following the pins through limp home
   chk_limp_monitor: assert property (@(posedge clk) disable iff (!rst_b)
      seq_limp_req |=> (input_level_monitor == {$past(direct_input_b), $past(direct_input_a)}))
      else $error("monitor stalled in limp home");

   // sleep blocks serial access as well as the detectors
   chk_sleep_access: assert property (@(posedge clk) disable iff (!rst_b)
      seq_sleep_req |=> (!serial_access_en && !limp_mode))
      else $error("serial access open in sleep");

   // sleep clears the channel-on register as any low request does
   chk_sleep_clear: assert property (@(posedge clk) disable iff (!rst_b)
      seq_sleep_req |=> (channel_on_reg == dpm_pkg::CH_ON_RESET))
      else $error("channel-on kept in sleep");

   // high request always decodes to normal mode
   chk_normal_flag: assert property (@(posedge clk) disable iff (!rst_b)
      seq_normal_req |=> (!sleep_mode && !limp_mode && serial_access_en))
      else $error("not normal with request high");

   // detectors run whenever the request is high
   chk_normal_uv: assert property (@(posedge clk) disable iff (!rst_b)
      seq_normal_req |=> uv_detect_en)
      else $error("undervoltage detect off in normal");

   // a write to map a lands on the next edge
   chk_map_a_write: assert property (@(posedge clk) disable iff (!rst_b)
      (low_power_req_b && wr_map_a) |=> (input_a_channel_map == $past(wdata)))
      else $error("map a write lost");

   // a write to the channel-on register lands on the next edge
   chk_chon_write: assert property (@(posedge clk) disable iff (!rst_b)
      (low_power_req_b && wr_ch_on) |=> (channel_on_reg == $past(wdata)))
      else $error("channel-on write lost");

   // map a holds its value while the request is high and nothing writes it
   chk_map_a_hold: assert property (@(posedge clk) disable iff (!rst_b)
      (low_power_req_b && !wr_map_a) |=> $stable(input_a_channel_map))
      else $error("map a changed without a write");

   // map b holds its value while the request is high and nothing writes it
   chk_map_b_hold: assert property (@(posedge clk) disable iff (!rst_b)
      (low_power_req_b && !wr_map_b) |=> $stable(input_b_channel_map))
      else $error("map b changed without a write");

   // writes to map b are refused while the request is low
   chk_map_b_blocked: assert property (@(posedge clk) disable iff (!rst_b)
      (!low_power_req_b && wr_map_b) |=> (input_b_channel_map == dpm_pkg::MAP_B_RESET))
      else $error("map b write taken in low power");

   // writes to channel-on are refused while the request is low
   chk_chon_blocked: assert property (@(posedge clk) disable iff (!rst_b)
      (!low_power_req_b && wr_ch_on) |=> (channel_on_reg == dpm_pkg::CH_ON_RESET))
      else $error("channel-on write taken in low power");

   // selected serial output drives the data in normal mode
   chk_so_drive: assert property (@(posedge clk) disable iff (!rst_b)
      (low_power_req_b && !serial_cs_b) |=> (serial_out_oe && serial_out == $past(serial_out_data)))
      else $error("serial output not driven");

   // deselected serial output is released in every mode
   chk_so_idle: assert property (@(posedge clk) disable iff (!rst_b)
      serial_cs_b |=> !serial_out_oe)
      else $error("serial output driven while deselected");

   // limp home keeps the serial output usable, only sleep releases it
   chk_so_limp: assert property (@(posedge clk) disable iff (!rst_b)
      (!low_power_req_b && (direct_input_a || direct_input_b) && !serial_cs_b) |=> serial_out_oe)
      else $error("serial output released in limp home");

   // with both inputs low in normal mode only the channel-on register switches channels on
   chk_no_stray_ch: assert property (@(posedge clk) disable iff (!rst_b)
      (low_power_req_b && !direct_input_a && !direct_input_b) |=> (channel_on == $past(cfg.ch_on)))
      else $error("channel on without a cause");
endmodule : dpm_top

// [testbench.sv]
// self-checking testbench for the direct pin mode block
`timescale 1ns/10ps
module testbench;
   logic clk = 1'b0, rst_b = 1'b0, a_cmd = 1'b0, b_cmd = 1'b0, req_cmd = 1'b1;
   logic in_a, in_b, req_b, wr_a = 1'b0, wr_b = 1'b0, wr_c = 1'b0, cs_b = 1'b1, sod = 1'b0;
   logic [7:0] wdata = 8'h00, chon, map_a, map_b, creg;
   logic [1:0] mon;
   logic slp, lmp, uv, acc, so, oe;
   int failures = 0, tests_run = 0;
   initial begin
      forever #10 clk = ~clk;
   end
   dpm_host_model host_u (.clk(clk), .a_cmd(a_cmd), .b_cmd(b_cmd), .req_cmd(req_cmd),
      .direct_input_a(in_a), .direct_input_b(in_b), .low_power_req_b(req_b));
   dpm_top dut_u (.clk(clk), .rst_b(rst_b), .direct_input_a(in_a), .direct_input_b(in_b),
      .low_power_req_b(req_b), .wr_map_a(wr_a), .wr_map_b(wr_b), .wr_ch_on(wr_c), .wdata(wdata),
      .serial_cs_b(cs_b), .serial_out_data(sod), .channel_on(chon), .input_a_channel_map(map_a),
      .input_b_channel_map(map_b), .channel_on_reg(creg), .input_level_monitor(mon),
      .sleep_mode(slp), .limp_mode(lmp), .uv_detect_en(uv), .serial_access_en(acc),
      .serial_out(so), .serial_out_oe(oe));
   task automatic conclude;
      if (failures == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : conclude
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   // three writes back to back, strobes held without a gap
   task automatic wr3(input logic [7:0] d0, input logic [7:0] d1, input logic [7:0] d2);
      logic [7:0] d[3];
      d = '{d0, d1, d2};
      for (int i = 0; i < 3; i++) begin
         {wr_a, wr_b, wr_c} = 3'h4 >> i;
         wdata = d[i];
         cyc(1);
      end
      {wr_a, wr_b, wr_c} = 3'h0;
      cyc(2);
   endtask : wr3
   // bounded wait for the mode flags, the host may delay the request
   task automatic wait_mode(input logic s, input logic l);
      int n = 0;
      while ({slp, lmp} !== {s, l}) begin
         cyc(1);
         n++;
         if (n > 30) begin
            failures++;
            $display("mismatch at %0t: mode change timed out", $time);
            conclude();
         end
      end
      cyc(2);
   endtask : wait_mode
   initial begin
      cyc(12);
      rst_b = 1'b1;
      cyc(2);
      chk({map_a, map_b} >> 4, 8'h40);
      chk(creg, dpm_pkg::CH_ON_RESET);
      cs_b = 1'b0;
      sod = 1'b1;
      cyc(2);
      chk({oe, so}, 8'h03);
      cs_b = 1'b1;
      a_cmd = 1'b1;
      b_cmd = 1'b1;
      cyc(3);
      chk(chon, 8'h0c);
      chk(mon, 2'h3);
      wr3(8'hf0, 8'h01, 8'h02);
      chk(map_a, 8'hf0);
      chk(map_b, 8'h01);
      b_cmd = 1'b0;
      cyc(3);
      chk(chon, 8'hf2);
      b_cmd = 1'b1;
      a_cmd = 1'b0;
      req_cmd = 1'b0;
      wait_mode(1'b0, 1'b1);
      chk(chon, 8'h08);
      chk(map_a, 8'h04);
      wr3(8'hff, 8'hff, 8'hff);
      chk(creg, 8'h00);
      a_cmd = 1'b1;
      cyc(3);
      chk(mon, 2'h3);
      chk(chon, 8'h0c);
      a_cmd = 1'b0;
      b_cmd = 1'b0;
      cs_b = 1'b0;
      sod = 1'b1;
      wait_mode(1'b1, 1'b0);
      chk({uv, acc, oe, chon[3:2]}, 8'h00);
      wr3(8'hff, 8'hff, 8'hff);
      chk(creg, 8'h00);
      req_cmd = 1'b1;
      cs_b = 1'b1;
      wait_mode(1'b0, 1'b0);
      chk({uv, acc}, 8'h03);
      chk(map_b, 8'h08);
      conclude();
   end
endmodule : testbench
